// [src/msiv_pkg.sv]
package msiv_pkg;

    // register offsets with the wide-address layout
    localparam logic [11:0] OFS_CAP     = 12'h048;
    localparam logic [11:0] OFS_ADDR_LO = 12'h04c;
    localparam logic [11:0] OFS_ADDR_HI = 12'h050;
    localparam logic [11:0] OFS_PAYLOAD = 12'h054;
    localparam logic [11:0] OFS_MASK    = 12'h058;
    localparam logic [11:0] OFS_STATUS  = 12'h05c;
    localparam logic [11:0] OFS_STEP    = 12'h004;

    // capability header and read-only control fields
    localparam logic [7:0]  CAP_ID      = 8'h05;
    localparam logic [7:0]  NEXT_PTR    = 8'h68;
    localparam logic [2:0]  VEC_CAP     = 3'h3;
    localparam logic [2:0]  ALLOC_RST   = 3'h0;
    localparam logic [2:0]  ALLOC_TWO   = 3'h1;
    localparam logic [2:0]  ALLOC_FOUR  = 3'h2;
    localparam logic [2:0]  ALLOC_EIGHT = 3'h3;
    localparam logic        ADDR64      = 1'b1;
    localparam logic        PVM         = 1'b1;

    // control field positions
    localparam int EN_BIT    = 16;
    localparam int ALLOC_LSB = 20;

    // source groups
    localparam int GRP_HP   = 0;
    localparam int GRP_BR   = 1;
    localparam int GRP_GPIO = 2;
    localparam int GRP_DB   = 3;
    localparam int GRP_ML   = 4;
    localparam int NGRP     = 5;
    localparam int NVEC     = 8;

    // vector numbers
    localparam logic [2:0] VEC0 = 3'h0;
    localparam logic [2:0] VEC1 = 3'h1;
    localparam logic [2:0] VEC2 = 3'h2;
    localparam logic [2:0] VEC3 = 3'h3;
    localparam logic [2:0] VEC4 = 3'h4;
    localparam logic [2:0] VEC5 = 3'h5;

    typedef enum logic [1:0] {
        MSIV_IDLE = 2'b00,
        MSIV_SEND = 2'b01
    } msiv_state_e;

endpackage : msiv_pkg

// [src/msiv_top.sv]
`timescale 1ns/1ps
module msiv_top (
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // configuration access
    input  wire logic        cfg_wr_in,
    input  wire logic        cfg_rd_in,
    input  wire logic [11:0] cfg_addr_in,
    input  wire logic [3:0]  cfg_be_in,
    input  wire logic [31:0] cfg_wdata_in,
    output logic      [31:0] cfg_rdata_out,
    output logic             cfg_rvalid_out,
    // port mode
    input  wire logic        bridged_isolation_in,
    input  wire logic        gpio_port_in,
    // interrupt sources, one-cycle pulses
    input  wire logic        hp_event_in,
    input  wire logic [3:0]  bridge_event_in,
    input  wire logic        ecc_event_in,
    input  wire logic        gpio_event_in,
    input  wire logic        doorbell_event_in,
    input  wire logic        mgmt_link_event_in,
    // legacy interrupt path
    input  wire logic        legacy_req_in,
    output logic             legacy_interrupt_output_n_out,
    output logic             intx_msg_allowed_out,
    // interrupt write toward host
    input  wire logic        msg_ack_in,
    output logic             msg_valid_out,
    output logic      [63:0] msg_addr_out,
    output logic             msg_addr64_out,
    output logic      [15:0] msg_data_out
);

    function automatic logic [11:0] ofs_sel(input logic [11:0] ofs);
        return msiv_pkg::ADDR64 ? ofs : 12'(ofs - msiv_pkg::OFS_STEP);
    endfunction : ofs_sel
    localparam logic [11:0] OFS_DATA_E = ofs_sel(msiv_pkg::OFS_PAYLOAD);
    localparam logic [11:0] OFS_MASK_E = ofs_sel(msiv_pkg::OFS_MASK);
    localparam logic [11:0] OFS_STAT_E = ofs_sel(msiv_pkg::OFS_STATUS);

    function automatic logic [31:0] merge_be(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_be

    // group to vector, per allocated count
    function automatic logic [2:0] vec_of(input int grp, input logic [2:0] alloc);
        logic [2:0] v;
        v = msiv_pkg::VEC0;
        case (alloc)
            msiv_pkg::ALLOC_TWO: begin
                v = (grp == msiv_pkg::GRP_BR) ? msiv_pkg::VEC1 : msiv_pkg::VEC0;
            end
            msiv_pkg::ALLOC_FOUR: begin
                case (grp)
                    msiv_pkg::GRP_BR:   v = msiv_pkg::VEC1;
                    msiv_pkg::GRP_GPIO: v = msiv_pkg::VEC2;
                    msiv_pkg::GRP_DB:   v = msiv_pkg::VEC3;
                    msiv_pkg::GRP_ML:   v = msiv_pkg::VEC3;
                    default:            v = msiv_pkg::VEC0;
                endcase
            end
            msiv_pkg::ALLOC_EIGHT: begin
                case (grp)
                    msiv_pkg::GRP_BR:   v = msiv_pkg::VEC1;
                    msiv_pkg::GRP_GPIO: v = msiv_pkg::VEC2;
                    msiv_pkg::GRP_DB:   v = msiv_pkg::VEC4;
                    msiv_pkg::GRP_ML:   v = msiv_pkg::VEC5;
                    default:            v = msiv_pkg::VEC0;
                endcase
            end
            default: v = msiv_pkg::VEC0;
        endcase
        return v;
    endfunction : vec_of
    localparam int NG = msiv_pkg::NGRP;
    logic        msi_en;
    logic [2:0]  alloc;
    logic [29:0] addr_lo;
    logic [31:0] addr_hi;
    logic [15:0] payload;
    logic [7:0]  mask;
    logic [NG-1:0] pend;
    msiv_pkg::msiv_state_e state;
    logic [2:0]    eff_alloc;
    logic [7:0]    mask_impl;
    logic [7:0]    vec_pend;
    logic [NG-1:0] grp_ev;
    logic [NG-1:0] grp_clr;
    logic          any_go;
    logic [2:0]    go_vec;
    logic [2:0]    low_sel;
    logic [31:0]   mrg_lo, mrg_pay, mrg_mask;
    assign eff_alloc = (alloc > msiv_pkg::VEC_CAP) ? msiv_pkg::VEC_CAP : alloc;
    assign mrg_lo   = merge_be({addr_lo, 2'b00}, cfg_wdata_in, cfg_be_in);
    assign mrg_pay  = merge_be({16'h0000, payload}, cfg_wdata_in, cfg_be_in);
    assign mrg_mask = merge_be({24'h000000, mask}, cfg_wdata_in, cfg_be_in);

    // implemented mask bits depend on mode and allocation
    always_comb begin
        mask_impl    = 8'h00;
        mask_impl[0] = 1'b1;
        mask_impl[1] = bridged_isolation_in && (eff_alloc >= msiv_pkg::ALLOC_TWO);
        mask_impl[2] = gpio_port_in && (eff_alloc >= msiv_pkg::ALLOC_FOUR);
        mask_impl[4] = (eff_alloc == msiv_pkg::ALLOC_EIGHT);
        mask_impl[5] = (eff_alloc == msiv_pkg::ALLOC_EIGHT);
    end

    // event gathering
    always_comb begin
        grp_ev                   = '0;
        grp_ev[msiv_pkg::GRP_HP] = hp_event_in;
        grp_ev[msiv_pkg::GRP_BR] = ((|bridge_event_in) && bridged_isolation_in)
                                   || ecc_event_in;
        grp_ev[msiv_pkg::GRP_GPIO] = gpio_event_in;
        grp_ev[msiv_pkg::GRP_DB]   = doorbell_event_in;
        grp_ev[msiv_pkg::GRP_ML]   = mgmt_link_event_in;
    end

    // per-vector pending view
    genvar gv;
    generate
        for (gv = 0; gv < msiv_pkg::NVEC; gv++) begin : g_vp
            always_comb begin
                vec_pend[gv] = 1'b0;
                for (int g = 0; g < NG; g++) begin
                    if (pend[g] && (vec_of(g, eff_alloc) == 3'(gv))) begin
                        vec_pend[gv] = 1'b1;
                    end
                end
            end
        end
    endgenerate

    // lowest pending vector whose mask is open wins
    always_comb begin
        any_go = 1'b0;
        go_vec = msiv_pkg::VEC0;
        for (int v = msiv_pkg::NVEC - 1; v >= 0; v--) begin
            if (vec_pend[v] && !(mask[v] && mask_impl[v])) begin
                any_go = 1'b1;
                go_vec = 3'(v);
            end
        end
        grp_clr = '0;
        for (int g = 0; g < NG; g++) begin
            grp_clr[g] = any_go && (state == msiv_pkg::MSIV_IDLE) && msi_en
                         && (vec_of(g, eff_alloc) == go_vec);
        end
    end

    assign low_sel = 3'((4'h1 << eff_alloc) - 4'h1);

    // configuration registers
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            msi_en  <= 1'b0;
            alloc   <= msiv_pkg::ALLOC_RST;
            addr_lo <= '0;
            addr_hi <= '0;
            payload <= '0;
            mask    <= 8'h00;
        end else if (cfg_wr_in) begin
            case (cfg_addr_in)
                msiv_pkg::OFS_CAP: begin
                    if (cfg_be_in[2]) begin
                        msi_en <= cfg_wdata_in[msiv_pkg::EN_BIT];
                        alloc  <= cfg_wdata_in[msiv_pkg::ALLOC_LSB +: 3];
                    end
                end
                msiv_pkg::OFS_ADDR_LO: addr_lo <= mrg_lo[31:2];
                OFS_DATA_E: payload <= mrg_pay[15:0];
                OFS_MASK_E: mask <= mrg_mask[7:0];
                default: begin
                    if (msiv_pkg::ADDR64 && cfg_addr_in == msiv_pkg::OFS_ADDR_HI) begin
                        addr_hi <= merge_be(addr_hi, cfg_wdata_in, cfg_be_in);
                    end
                end
            endcase
        end
    end

    // read path, one cycle latency
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cfg_rdata_out  <= '0;
            cfg_rvalid_out <= 1'b0;
        end else begin
            cfg_rvalid_out <= cfg_rd_in;
            cfg_rdata_out  <= '0;
            if (cfg_rd_in) begin
                case (cfg_addr_in)
                    msiv_pkg::OFS_CAP: cfg_rdata_out <= {7'h00, msiv_pkg::PVM,
                        msiv_pkg::ADDR64, alloc, msiv_pkg::VEC_CAP, msi_en,
                        msiv_pkg::NEXT_PTR, msiv_pkg::CAP_ID};
                    msiv_pkg::OFS_ADDR_LO: cfg_rdata_out <= {addr_lo, 2'b00};
                    OFS_DATA_E: cfg_rdata_out <= {16'h0000, payload};
                    OFS_MASK_E: cfg_rdata_out <= {24'h000000, mask};
                    OFS_STAT_E: cfg_rdata_out <= {24'h000000, vec_pend & mask_impl};
                    default: begin
                        if (msiv_pkg::ADDR64 && cfg_addr_in == msiv_pkg::OFS_ADDR_HI) begin
                            cfg_rdata_out <= addr_hi;
                        end
                    end
                endcase
            end
        end
    end

    // pending: a new event beats the clear of the same group
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pend <= '0;
        end else begin
            pend <= (pend & ~grp_clr) | (grp_ev & {NG{msi_en}});
        end
    end

    // interrupt write sequencer
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state          <= msiv_pkg::MSIV_IDLE;
            msg_valid_out  <= 1'b0;
            msg_addr_out   <= '0;
            msg_addr64_out <= 1'b0;
            msg_data_out   <= '0;
        end else begin
            case (state)
                msiv_pkg::MSIV_IDLE: begin
                    if (msi_en && any_go) begin
                        state          <= msiv_pkg::MSIV_SEND;
                        msg_valid_out  <= 1'b1;
                        msg_addr_out   <= {(msiv_pkg::ADDR64 ? addr_hi : 32'h00000000),
                                           addr_lo, 2'b00};
                        msg_addr64_out <= msiv_pkg::ADDR64 && (addr_hi != 32'h00000000);
                        msg_data_out   <= {payload[15:3],
                                           (payload[2:0] & ~low_sel) | (go_vec & low_sel)};
                    end
                end
                msiv_pkg::MSIV_SEND: begin
                    if (msg_ack_in) begin
                        state         <= msiv_pkg::MSIV_IDLE;
                        msg_valid_out <= 1'b0;
                    end
                end
                default: begin
                    state         <= msiv_pkg::MSIV_IDLE;
                    msg_valid_out <= 1'b0;
                end
            endcase
        end
    end

    // legacy path muted while messages are on
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            legacy_interrupt_output_n_out <= 1'b1;
            intx_msg_allowed_out          <= 1'b0;
        end else begin
            legacy_interrupt_output_n_out <= !(legacy_req_in && !msi_en);
            intx_msg_allowed_out          <= legacy_req_in && !msi_en;
        end
    end

    a_legacy_muted: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        msi_en && $past(msi_en) |-> legacy_interrupt_output_n_out && !intx_msg_allowed_out)
        else $error("legacy interrupt active while messages enabled");

    a_cap_fields: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        cfg_rd_in && cfg_addr_in == msiv_pkg::OFS_CAP
        |=> cfg_rdata_out[24:23] == 2'b11 && cfg_rdata_out[19:17] == 3'h3)
        else $error("capability fields read wrong");

    a_alloc_reset: assert property (@(posedge ref_clk_in)
        $past(rst_in) |-> alloc == 3'h0 && mask == 8'h00)
        else $error("allocation or mask not cleared by reset");

    a_no_top_vec: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        $rose(msg_valid_out) && $past(eff_alloc) == 3'h3 |-> msg_data_out[2:0] < 3'h6)
        else $error("unused vector generated");

    a_single_merge: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        $rose(msg_valid_out) && $past(eff_alloc) == 3'h0
        |-> msg_data_out == $past(payload))
        else $error("single vector payload altered");

    a_addr_source: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        $rose(msg_valid_out)
        |-> msg_addr_out == {$past(addr_hi), $past(addr_lo), 2'b00})
        else $error("write address not from registers");

    a_send_prompt: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state == msiv_pkg::MSIV_IDLE && msi_en && any_go |=> msg_valid_out)
        else $error("unmasked pending vector not sent");

    a_mask_holds: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        pend[msiv_pkg::GRP_HP] && eff_alloc == 3'h2 && mask[0] && !cfg_wr_in
        |=> pend[msiv_pkg::GRP_HP] [*2])
        else $error("masked event lost");

    a_valid_held: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        msg_valid_out && !msg_ack_in |=> msg_valid_out && $stable(msg_data_out))
        else $error("write request dropped before acknowledge");

endmodule : msiv_top

// [tb/msiv_host_model.sv]
`timescale 1ns/1ps
module msiv_host_model (
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // acceptance delay in cycles, zero for a prompt host
    input  wire logic [3:0]  ack_delay_in,
    // interrupt write from the port
    input  wire logic        msg_valid_in,
    input  wire logic [63:0] msg_addr_in,
    input  wire logic [15:0] msg_data_in,
    output logic             msg_ack_out,
    // record of accepted writes
    output logic [7:0]       wr_cnt_out,
    output logic [63:0]      last_addr_out,
    output logic [15:0]      last_data_out
);
    logic [3:0] wait_cnt;

    // ack stands one cycle, only while the write is held, so a stale ack never leaks
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            msg_ack_out <= 1'b0;
            wait_cnt    <= 4'h0;
            wr_cnt_out  <= 8'h00;
        end else if (msg_valid_in && !msg_ack_out) begin
            if (wait_cnt >= ack_delay_in) begin
                msg_ack_out   <= 1'b1;
                wait_cnt      <= 4'h0;
                wr_cnt_out    <= wr_cnt_out + 8'h01;
                last_addr_out <= msg_addr_in;
                last_data_out <= msg_data_in;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end else begin
            msg_ack_out <= 1'b0;
        end
    end
endmodule : msiv_host_model

// [tb/tb_msiv_top.sv]
`timescale 1ns/1ps
module tb_msiv_top;
    logic        clk, rst, wr, rd, lreq, ack, rvalid, leg_n, intx, mval, a64, iso, gport;
    logic [11:0] addr;
    logic [3:0]  be, dly;
    logic [31:0] wd, rdata;
    logic [63:0] maddr, laddr;
    logic [15:0] mdata, ldata;
    logic [5:0]  ev;
    logic [1:0]  bsel;
    logic [7:0]  wcnt;
    int          error_cnt = 0, cmp_count = 0, seen = 0, cyc = 0;
    localparam logic [15:0] PAY = 16'h5a5f;
    localparam logic [31:0] ALO = 32'h89ab_cdef;
    localparam logic [31:0] AHI = 32'h0000_0123;

    msiv_top msiv_top_i (.ref_clk_in(clk), .rst_in(rst), .cfg_wr_in(wr), .cfg_rd_in(rd),
        .cfg_addr_in(addr), .cfg_be_in(be), .cfg_wdata_in(wd), .cfg_rdata_out(rdata),
        .cfg_rvalid_out(rvalid), .bridged_isolation_in(iso), .gpio_port_in(gport),
        .hp_event_in(ev[0]), .bridge_event_in(ev[1] ? (4'h1 << bsel) : 4'h0),
        .ecc_event_in(ev[2]), .gpio_event_in(ev[3]), .doorbell_event_in(ev[4]),
        .mgmt_link_event_in(ev[5]), .legacy_req_in(lreq),
        .legacy_interrupt_output_n_out(leg_n), .intx_msg_allowed_out(intx),
        .msg_ack_in(ack), .msg_valid_out(mval), .msg_addr_out(maddr),
        .msg_addr64_out(a64), .msg_data_out(mdata));

    msiv_host_model msiv_host_model_i (.ref_clk_in(clk), .rst_in(rst), .ack_delay_in(dly),
        .msg_valid_in(mval), .msg_addr_in(maddr), .msg_data_in(mdata), .msg_ack_out(ack),
        .wr_cnt_out(wcnt), .last_addr_out(laddr), .last_data_out(ldata));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // hang guard, far above the several hundred cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            error_cnt++;
            finish_test();
        end
    end

    task check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task cfg_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wd <= d;
        be <= b;
        @(posedge clk);
        wr <= 1'b0;
    endtask : cfg_write

    task cfg_read(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rvalid, 1'b1);
        check(rdata, exp);
    endtask : cfg_read

    task set_alloc(input logic [2:0] a, input logic en);
        cfg_write(msiv_pkg::OFS_CAP, {9'h0, a, 3'h0, en, 16'h0}, 4'h4);
    endtask : set_alloc

    task fire(input int g);
        @(posedge clk);
        ev <= 6'h1 << g;
        @(posedge clk);
        ev <= 6'h0;
    endtask : fire

    // waits for the next accepted write and checks address and vector in the payload
    task wait_msg(input logic [2:0] v, input logic [2:0] a);
        int t;
        logic [15:0] m;
        t = 0;
        m = (16'h1 << a) - 16'h1;
        while (wcnt == seen[7:0] && t < 40) begin
            @(posedge clk);
            t++;
        end
        seen++;
        check(wcnt, seen[7:0]);
        check(ldata, (PAY & ~m) | {13'h0, v});
        check(laddr, {AHI, ALO & 32'hffff_fffc});
        check(a64, 1'b1);
    endtask : wait_msg

    task no_msg;
        repeat (8) @(posedge clk);
        check(wcnt, seen[7:0]);
    endtask : no_msg

    // vector expected per effective allocation code and event input index
    function automatic logic [2:0] exp_vec(input int a, input int g);
        case (g)
            1, 2: return (a > 0) ? 3'h1 : 3'h0;
            3: return (a > 1) ? 3'h2 : 3'h0;
            4: return (a == 3) ? 3'h4 : ((a == 2) ? 3'h3 : 3'h0);
            5: return (a == 3) ? 3'h5 : ((a == 2) ? 3'h3 : 3'h0);
            default: return 3'h0;
        endcase
    endfunction : exp_vec

    logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic [2:0] m_al  [4] = '{3'h2, 3'h0, 3'h1, 3'h2};
    logic [7:0] m_bit [4] = '{8'h01, 8'h01, 8'h02, 8'h04};
    int         m_grp [4] = '{0, 2, 1, 3};
    logic [2:0] m_vec [4] = '{3'h0, 3'h0, 3'h1, 3'h2};
    logic [2:0] e;

    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 12'h000;
        be = 4'h0;
        wd = 32'h0;
        lreq = 1'b0;
        ev = 6'h0;
        bsel = 2'h0;
        dly = 4'h0;
        iso = 1'b1;
        gport = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        cfg_read(msiv_pkg::OFS_CAP, 32'h0186_6805);
        cfg_read(msiv_pkg::OFS_MASK, 32'h0);
        cfg_read(12'h060, 32'h0);
        cfg_write(msiv_pkg::OFS_ADDR_LO, ALO, 4'hf);
        cfg_write(msiv_pkg::OFS_ADDR_HI, AHI, 4'hf);
        cfg_write(msiv_pkg::OFS_PAYLOAD, {16'hffff, PAY}, 4'hf);
        cfg_read(msiv_pkg::OFS_ADDR_LO, ALO & 32'hffff_fffc);
        cfg_read(msiv_pkg::OFS_ADDR_HI, AHI);
        cfg_read(msiv_pkg::OFS_PAYLOAD, {16'h0, PAY});
        @(posedge clk);
        lreq <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(leg_n, 1'b0);
        check(intx, 1'b1);
        fire(0);
        no_msg();
        set_alloc(3'h0, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        check(leg_n, 1'b1);
        check(intx, 1'b0);
        for (int i = 0; i < 5; i++) begin
            e = (codes[i] > 3'h3) ? 3'h3 : codes[i];
            set_alloc(codes[i], 1'b1);
            bsel <= i[1:0];
            for (int g = 0; g < 6; g++) begin
                dly <= 4'(g * 2);
                fire(g);
                wait_msg(exp_vec(e, g), e);
            end
        end
        @(posedge clk);
        ev <= 6'h09;
        @(posedge clk);
        ev <= 6'h0;
        wait_msg(3'h0, 3'h3);
        wait_msg(3'h2, 3'h3);
        for (int i = 0; i < 4; i++) begin
            set_alloc(m_al[i], 1'b1);
            cfg_write(msiv_pkg::OFS_MASK, {24'h0, m_bit[i]}, 4'h1);
            fire(m_grp[i]);
            no_msg();
            if (i == 0) begin
                fire(5);
                wait_msg(3'h3, 3'h2);
            end
            cfg_read(msiv_pkg::OFS_STATUS, 32'h1 << m_vec[i]);
            cfg_write(msiv_pkg::OFS_MASK, 32'h0, 4'h1);
            wait_msg(m_vec[i], m_al[i]);
            no_msg();
        end
        // plain port: bridge events dropped, mask bits 1 and 2 have no effect
        iso <= 1'b0;
        gport <= 1'b0;
        cfg_write(msiv_pkg::OFS_MASK, 32'h6, 4'h1);
        fire(1);
        no_msg();
        fire(2);
        wait_msg(3'h1, 3'h2);
        fire(3);
        wait_msg(3'h2, 3'h2);
        cfg_read(msiv_pkg::OFS_STATUS, 32'h0);
        finish_test();
    end
endmodule : tb_msiv_top
